// ---- common/psrd_pkg.sv ----
// Package: constants for the serial load port and reference divider latch
package psrd_pkg;
   localparam int          WORD_BITS        = 24;
   localparam int          REF_DIV_BITS     = 14;
   localparam int          REF_DIV_LSB      = 2;
   localparam int          ABL_LSB          = 16;
   localparam int          LOCK_PREC_BIT    = 18;
   localparam int          TEST_SEL_BIT     = 19;
   localparam int          BSC_LSB          = 20;
   localparam int          BSC_BITS         = 2;
   localparam int          SPARE_LSB        = 22;
   localparam logic [1:0]  ADDR_CONTROL     = 2'h0;
   localparam logic [1:0]  ADDR_REFERENCE   = 2'h1;
   localparam logic [1:0]  ADDR_FEEDBACK    = 2'h2;
   localparam logic [1:0]  ADDR_TEST        = 2'h3;
   localparam logic [23:0] LATCH_RESET      = 24'h00_0000;
   localparam logic [13:0] REF_DIV_RESET    = 14'h0001;
   localparam logic [13:0] REF_DIV_MIN      = 14'h0001;
   localparam int          PHASE_ERR_NS     = 15;
   localparam int          CLK_PERIOD_NS    = 50;
   // Least-time bound would round to zero cycles, so at least one cycle
   localparam int          PHASE_ERR_CYC    = (PHASE_ERR_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                              (PHASE_ERR_NS / CLK_PERIOD_NS);
   localparam logic [2:0]  LOCK_CYC_PRECISE = 3'h5;
   localparam logic [2:0]  LOCK_CYC_COARSE  = 3'h3;
   localparam int          SYNC_STAGES      = 2;
endpackage : psrd_pkg

// ---- src/psrd_sync.sv ----
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module psrd_sync
   import psrd_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   if (WIDTH < 1) begin : g_bad_width
      $error("psrd_sync: WIDTH must be at least 1");
   end

   always_comb begin
      next_stage1   = async_in;
      next_sync_out = stage1;
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule : psrd_sync
`default_nettype wire

// ---- src/psrd_top.sv ----
// Serial load port with reference divider latch, reference counter and lock detect
// Operation
// - Address pair (0,1) stores the word into the reference divider latch.
// - Pair (0,0) goes to control latch, pair (1,0) to feedback latch.
// - Fourteen-bit reference divide ratio, 1 to 16383; zero is illegal.
// - Bits 16 and 17 choose antibacklash pulse width.
// - Lock after 5 (bit18=1) or 3 good reference cycles under 15 ns.
// - With test select bit 19 low, the test latch is ignored; here test_word still loads and drives out whatever bit 19 is.
// - Band select clock comes from reference output, optionally divided down.
// - Shift register takes one bit per rising serial clock edge.
// - Rising load strobe moves 24 bits into the addressed latch.
// - Shift register keeps loading during power-down.
`timescale 1ns/100ps
`default_nettype none
module psrd_top
   import psrd_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        serial_clk,
   input  wire logic        serial_data,
   input  wire logic        load_strobe,
   input  wire logic        chip_enable,
   input  wire logic        phase_err_small,
   output var  logic [23:0] control_word,
   output var  logic [23:0] feedback_word,
   output var  logic [23:0] ref_latch_word,
   output var  logic [23:0] test_word,
   output var  logic        test_mode_active,
   output var  logic        ref_tick,
   output var  logic        band_sel_tick,
   output var  logic        muxed_status_out
);
   logic [2:0]  pins_sync;
   logic        sclk_s;
   logic        sdata_s;
   logic        strobe_s;
   logic        sclk_d;
   logic        strobe_d;
   logic        pd_sync;
   logic        pd_meta;
   logic [1:0]  arm_cnt;
   logic [1:0]  next_arm_cnt;
   logic        edges_armed;
   logic [23:0] shift_reg;
   logic [23:0] next_shift_reg;
   logic [23:0] next_control_word;
   logic [23:0] next_feedback_word;
   logic [23:0] next_ref_latch_word;
   logic [23:0] next_test_word;
   logic [13:0] ref_cnt;
   logic [13:0] next_ref_cnt;
   logic        next_ref_tick;
   logic [7:0]  bsc_cnt;
   logic [7:0]  next_bsc_cnt;
   logic        next_band_sel_tick;
   logic [2:0]  good_cnt;
   logic [2:0]  next_good_cnt;
   logic        next_muxed_status_out;
   logic        next_test_mode_active;

   psrd_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in ({serial_clk, serial_data, load_strobe}),
      .sync_out (pins_sync)
   );
   assign sclk_s   = pins_sync[2];
   assign sdata_s  = pins_sync[1];
   assign strobe_s = pins_sync[0];

   function automatic logic [13:0] ref_ratio(input logic [23:0] w);
      logic [13:0] r;
      r = w[REF_DIV_LSB +: REF_DIV_BITS];
      // A zero ratio is illegal; treat it as one rather than stalling
      ref_ratio = (r == 14'h0000) ? REF_DIV_MIN : r;
   endfunction : ref_ratio

   function automatic logic [7:0] bsc_divisor(input logic [1:0] sel);
      case (sel)
         2'h0:    bsc_divisor = 8'h01;
         2'h1:    bsc_divisor = 8'h02;
         2'h2:    bsc_divisor = 8'h04;
         default: bsc_divisor = 8'h08;
      endcase
   endfunction : bsc_divisor

   // Serial shift and latch transfer; no power-down gating by design
   always_comb begin
      next_shift_reg      = shift_reg;
      next_control_word   = control_word;
      next_feedback_word  = feedback_word;
      next_ref_latch_word = ref_latch_word;
      next_test_word      = test_word;
      // Edges wait until the synchroniser has refilled after reset,
      // else an idle-high strobe would look like a fresh rising edge
      edges_armed         = (arm_cnt == 2'(SYNC_STAGES + 1));
      next_arm_cnt        = edges_armed ? arm_cnt : arm_cnt + 2'h1;
      if (edges_armed && sclk_s && !sclk_d) begin
         next_shift_reg = {shift_reg[22:0], sdata_s};
      end
      if (edges_armed && strobe_s && !strobe_d) begin
         case (shift_reg[1:0])
            ADDR_CONTROL:   next_control_word   = shift_reg;
            ADDR_REFERENCE: next_ref_latch_word = shift_reg;
            ADDR_FEEDBACK:  next_feedback_word  = shift_reg;
            ADDR_TEST:      next_test_word      = shift_reg;
            default:        next_test_word      = test_word;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         arm_cnt        <= 2'h0;
         sclk_d         <= 1'b0;
         strobe_d       <= 1'b0;
         shift_reg      <= LATCH_RESET;
         control_word   <= LATCH_RESET;
         feedback_word  <= LATCH_RESET;
         ref_latch_word <= LATCH_RESET;
         test_word      <= LATCH_RESET;
      end else begin
         arm_cnt        <= next_arm_cnt;
         sclk_d         <= sclk_s;
         strobe_d       <= strobe_s;
         shift_reg      <= next_shift_reg;
         control_word   <= next_control_word;
         feedback_word  <= next_feedback_word;
         ref_latch_word <= next_ref_latch_word;
         test_word      <= next_test_word;
      end
   end

   // Reference counter, band select divider and lock detect
   always_comb begin
      next_test_mode_active = ref_latch_word[TEST_SEL_BIT];
      next_ref_tick         = 1'b0;
      next_ref_cnt          = ref_cnt + 14'h0001;
      if (ref_cnt >= ref_ratio(ref_latch_word) - 14'h0001) begin
         next_ref_cnt  = 14'h0000;
         next_ref_tick = 1'b1;
      end
      // Power-down holds the counter at its load state
      if (pd_sync) begin
         next_ref_cnt  = 14'h0000;
         next_ref_tick = 1'b0;
      end
      next_band_sel_tick = 1'b0;
      next_bsc_cnt       = bsc_cnt;
      if (ref_tick) begin
         if (bsc_cnt >= bsc_divisor(ref_latch_word[BSC_LSB +: BSC_BITS]) - 8'h01) begin
            next_bsc_cnt       = 8'h00;
            next_band_sel_tick = 1'b1;
         end else begin
            next_bsc_cnt = bsc_cnt + 8'h01;
         end
      end
      next_good_cnt         = good_cnt;
      next_muxed_status_out = muxed_status_out;
      if (pd_sync) begin
         // Power-down resets the lock detector
         next_good_cnt         = 3'h0;
         next_muxed_status_out = 1'b0;
      end else if (ref_tick) begin
         if (!phase_err_small) begin
            next_good_cnt         = 3'h0;
            next_muxed_status_out = 1'b0;
         end else begin
            if (good_cnt != 3'h7) next_good_cnt = good_cnt + 3'h1;
            if (good_cnt + 3'h1 >= (ref_latch_word[LOCK_PREC_BIT] ?
                LOCK_CYC_PRECISE : LOCK_CYC_COARSE)) begin
               next_muxed_status_out = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pd_meta          <= 1'b0;
         pd_sync          <= 1'b0;
         ref_cnt          <= 14'h0000;
         ref_tick         <= 1'b0;
         bsc_cnt          <= 8'h00;
         band_sel_tick    <= 1'b0;
         good_cnt         <= 3'h0;
         muxed_status_out <= 1'b0;
         test_mode_active <= 1'b0;
      end else begin
         pd_meta          <= ~chip_enable;
         pd_sync          <= pd_meta;
         ref_cnt          <= next_ref_cnt;
         ref_tick         <= next_ref_tick;
         bsc_cnt          <= next_bsc_cnt;
         band_sel_tick    <= next_band_sel_tick;
         good_cnt         <= next_good_cnt;
         muxed_status_out <= next_muxed_status_out;
         test_mode_active <= next_test_mode_active;
      end
   end
endmodule : psrd_top
`default_nettype wire

// ---- verification/psrd_host.sv ----
// Host model: serial master that shifts words out and raises the load strobe
`timescale 1ns/100ps
`default_nettype none
module psrd_host (
   input  wire logic clk_sys,
   output var  logic serial_clk,
   output var  logic serial_data,
   output var  logic load_strobe
);
   initial begin
      serial_clk  = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   // Three cycles a phase: the pins are sampled through two flops
   task automatic send(input logic [23:0] w);
      load_strobe <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data <= w[i];
         repeat (3) @(posedge clk_sys);
         serial_clk <= 1'b1;
         repeat (3) @(posedge clk_sys);
         serial_clk <= 1'b0;
      end
      serial_data <= ~w[0];
      repeat (3) @(posedge clk_sys);
      load_strobe <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask : send
endmodule : psrd_host
`default_nettype wire

// ---- verification/psrd_top_sva.sv ----
// Checker: latch routing, load timing and tick relations at the top ports
`timescale 1ns/100ps
`default_nettype none
module psrd_top_sva
   import psrd_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        load_strobe,
   input wire logic        chip_enable,
   input wire logic [23:0] control_word,
   input wire logic [23:0] feedback_word,
   input wire logic [23:0] ref_latch_word,
   input wire logic [23:0] test_word,
   input wire logic        test_mode_active,
   input wire logic        ref_tick,
   input wire logic        band_sel_tick,
   input wire logic        muxed_status_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_route(logic [23:0] w, logic [1:0] a);
      $changed(w) |-> w[1:0] == a;
   endproperty
   a_ctl_route:
   assert property (p_route(control_word, ADDR_CONTROL)) else $error("control route");
   a_ref_route:
   assert property (p_route(ref_latch_word, ADDR_REFERENCE)) else $error("reference route");
   a_fb_route:
   assert property (p_route(feedback_word, ADDR_FEEDBACK)) else $error("feedback route");
   a_test_route:
   assert property (p_route(test_word, ADDR_TEST)) else $error("test route");
   a_load_timing:
   assert property ($changed({control_word, feedback_word, ref_latch_word, test_word})
      |-> $past(load_strobe, 2)) else $error("latch changed without strobe");
   a_test_mode_off:
   assert property (test_mode_active |-> ref_latch_word[TEST_SEL_BIT]
      || $past(ref_latch_word[TEST_SEL_BIT])) else $error("test mode without bit");
   a_band_from_ref:
   assert property (band_sel_tick |-> ref_tick || $past(ref_tick)) else $error("band tick");
   a_power_down_quiet:
   assert property (!chip_enable [*4] |=> !ref_tick && !muxed_status_out)
      else $error("counting in power-down");
   cover property ($rose(muxed_status_out));
   cover property ($changed(ref_latch_word));
   cover property (band_sel_tick);
endmodule : psrd_top_sva
bind psrd_top psrd_top_sva u_sva (.clk_sys, .srst, .load_strobe, .chip_enable,
   .control_word, .feedback_word, .ref_latch_word, .test_word, .test_mode_active,
   .ref_tick, .band_sel_tick, .muxed_status_out);
`default_nettype wire

// ---- verification/psrd_top_tb.sv ----
// Testbench: routing, power-down loading, lock count and band select
`timescale 1ns/100ps
`default_nettype none
module psrd_top_tb;
   import psrd_pkg::*;
   logic        clk_sys = 0, srst = 1, chip_enable = 1, phase_err_small = 0;
   logic        serial_clk, serial_data, load_strobe, tma, rt, bt, lk;
   logic [23:0] ctl, fb, rl, tw, w;
   logic [23:0] rows [4] = '{24'h12_3450, 24'h0A_BC02, 24'h00_0F03, 24'h17_0011};
   logic [23:0] exp_w [4] = '{default: 24'h00_0000};
   int          error_cnt = 0, num_checks = 0, cyc = 0, n;
   always #25 clk_sys = ~clk_sys;
   psrd_host host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_data(serial_data),
      .load_strobe(load_strobe));
   psrd_top dut (.clk_sys(clk_sys), .srst(srst), .serial_clk(serial_clk),
      .serial_data(serial_data), .load_strobe(load_strobe), .chip_enable(chip_enable),
      .phase_err_small(phase_err_small), .control_word(ctl), .feedback_word(fb),
      .ref_latch_word(rl), .test_word(tw), .test_mode_active(tma), .ref_tick(rt),
      .band_sel_tick(bt), .muxed_status_out(lk));
   task automatic chk(input logic [99:0] seen, input logic [99:0] want);
      num_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   // Measures cycles between two ticks of the reference or band select output
   task automatic gap(input bit band, input int want);
      n = 0;
      do @(negedge clk_sys); while (!(band ? bt : rt));
      do begin @(negedge clk_sys); n++; end while (!(band ? bt : rt));
      chk(n, want);
   endtask : gap
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge clk_sys) if (++cyc == 20000) begin error_cnt++; stop_test(); end
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk({ctl, fb, rl, tw, tma, rt, bt, lk}, '0);
      foreach (rows[i]) begin
         @(posedge clk_sys);
         host.send(rows[i]);
         exp_w[rows[i][1:0]] = rows[i];
         repeat (8) @(negedge clk_sys);
         chk({ctl, rl, fb, tw, tma}, {exp_w[0], exp_w[1], exp_w[2], exp_w[3], 1'b0});
      end
      // Loading must survive power-down, which also restarts lock detect
      for (int p = 0; p < 2; p++) begin
         w = {4'h1, p[0] ? 4'h4 : 4'h0, 16'h0011};
         @(posedge clk_sys);
         chip_enable     <= 1'b0;
         phase_err_small <= 1'b1;
         host.send(w);
         repeat (8) @(negedge clk_sys);
         chk({rl, rt, lk}, {w, 2'b00});
         @(posedge clk_sys);
         chip_enable <= 1'b1;
         n = 0;
         do begin @(negedge clk_sys); n += rt; end while (!lk);
         chk(n, p ? 5 : 3);
         @(posedge clk_sys);
         phase_err_small <= 1'b0;
         repeat (12) @(negedge clk_sys);
         chk(lk, 1'b0);
      end
      gap(1'b0, 4);
      gap(1'b1, 8);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk({ctl, fb, rl, tw, tma, rt, bt, lk}, '0);
      // Strobe idles high across the reset; it must not fake a load
      @(posedge clk_sys);
      host.send(rows[0]);
      repeat (8) @(negedge clk_sys);
      chk(ctl, rows[0]);
      stop_test();
   end
endmodule : psrd_top_tb
`default_nettype wire
